// >>> secl_loader.sv
// Summary of operation
// - Device is SPI master: drives clock, select, data in; samples data out.
// - Fetching starts once the fundamental reset input is released.
// - Memory holds 16-bit words, each access sends an 8-bit word address.
// - Sequencer does single-word read or write on a software request.
// - Word zero must match the signature, else loading is skipped.
// - Autoload reads consecutive words and writes each one after word zero to its register.
// - Status bit 4 of offset A0h goes high when loading completes.
// - Per-port PM words come from byte offsets 50h to 5Ah.
// - Per-port TC/VC map words come from byte offsets 60h to 6Ah.
`timescale 1ns/1ps
`default_nettype none

module secl_loader (
	input  wire logic                  mclk_i,
	input  wire logic                  rstn_i,
	input  wire logic                  fundamental_reset_n_i,
	input  wire logic                  cfgmem_data_out_i,
	input  wire secl_pkg::secl_req_t   req_i,
	output logic                       cfgmem_serial_clock_o,
	output logic                       cfgmem_chip_select_o,
	output logic                       cfgmem_data_in_o,
	output secl_pkg::secl_cfg_wr_t     cfg_wr_o,
	output logic [15:0]                status_o,
	output logic [15:0]                rdata_o,
	output logic                       pm_wr_o,
	output logic                       tcvc_wr_o
);

	// ==========================================================
	// Input synchronisers
	logic [1:0] perst_sync_r, perst_sync_nxt;
	logic [1:0] miso_sync_r, miso_sync_nxt;

	always_comb begin
		perst_sync_nxt = {perst_sync_r[0], fundamental_reset_n_i};
		miso_sync_nxt  = {miso_sync_r[0], cfgmem_data_out_i};
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			perst_sync_r <= 2'h0;
			miso_sync_r  <= 2'h0;
		end else begin
			perst_sync_r <= perst_sync_nxt;
			miso_sync_r  <= miso_sync_nxt;
		end
	end

	// ==========================================================
	// Sequencer
	typedef enum {ST_RESET, ST_WREN, ST_GAP, ST_XFER, ST_DONE_XFER,
		ST_IDLE} secl_state_t;

	secl_state_t            state_r, state_nxt;
	logic                   auto_r, auto_nxt;
	logic                   wr_r, wr_nxt;
	logic [7:0]             addr_r, addr_nxt;
	logic [31:0]            shreg_r, shreg_nxt;
	logic [5:0]             bits_r, bits_nxt;
	logic [2:0]             div_r, div_nxt;
	logic                   sck_r, sck_nxt;
	logic                   cs_r, cs_nxt;
	logic                   mosi_r, mosi_nxt;
	logic                   done_r, done_nxt;
	logic [15:0]            rdata_r, rdata_nxt;
	secl_pkg::secl_cfg_wr_t cfg_r, cfg_nxt;
	logic                   pm_r, pm_nxt;
	logic                   tcvc_r, tcvc_nxt;
	logic                   half_end;

	assign half_end = (div_r == 3'(secl_pkg::HALF_CYC - 1));

	always_comb begin
		state_nxt = state_r;
		auto_nxt  = auto_r;
		wr_nxt    = wr_r;
		addr_nxt  = addr_r;
		shreg_nxt = shreg_r;
		bits_nxt  = bits_r;
		div_nxt   = div_r;
		sck_nxt   = sck_r;
		cs_nxt    = cs_r;
		mosi_nxt  = mosi_r;
		done_nxt  = done_r;
		rdata_nxt = rdata_r;
		cfg_nxt   = '0;
		pm_nxt    = 1'b0;
		tcvc_nxt  = 1'b0;
		unique case (state_r)
			// wait for fundamental reset release, then read word zero
			ST_RESET: begin
				if (perst_sync_r[1]) begin
					auto_nxt  = 1'b1;
					wr_nxt    = 1'b0;
					addr_nxt  = secl_pkg::SIG_ADDR;
					shreg_nxt = {secl_pkg::OP_READ, secl_pkg::SIG_ADDR,
						16'h0000};
					bits_nxt  = secl_pkg::BITS_RD;
					cs_nxt    = 1'b0;
					div_nxt   = 3'h0;
					mosi_nxt  = secl_pkg::OP_READ[7];
					state_nxt = ST_XFER;
				end
			end
			// write enable latch command before a word write
			ST_WREN: begin
				if (half_end) begin
					div_nxt = 3'h0;
					sck_nxt = ~sck_r;
					if (sck_r) begin
						shreg_nxt = {shreg_r[30:0], 1'b0};
						mosi_nxt  = shreg_r[30];
						bits_nxt  = bits_r - 6'h1;
						if (bits_r == 6'h1) begin
							cs_nxt    = 1'b1;
							state_nxt = ST_GAP;
						end
					end
				end else begin
					div_nxt = div_r + 3'h1;
				end
			end
			ST_GAP: begin
				if (half_end) begin
					div_nxt   = 3'h0;
					cs_nxt    = 1'b0;
					shreg_nxt = {secl_pkg::OP_WRITE, addr_r, rdata_r};
					mosi_nxt  = secl_pkg::OP_WRITE[7];
					bits_nxt  = secl_pkg::BITS_WR;
					state_nxt = ST_XFER;
				end else begin
					div_nxt = div_r + 3'h1;
				end
			end
			// master clocking; opcode, address MSB first, 16 bits
			ST_XFER: begin
				if (half_end) begin
					div_nxt = 3'h0;
					sck_nxt = ~sck_r;
					if (!sck_r) begin
						shreg_nxt = {shreg_r[30:0], miso_sync_r[1]};
					end else begin
						mosi_nxt = shreg_r[31];
						bits_nxt = bits_r - 6'h1;
						if (bits_r == 6'h1) begin
							cs_nxt    = 1'b1;
							state_nxt = ST_DONE_XFER;
						end
					end
				end else begin
					div_nxt = div_r + 3'h1;
				end
			end
			ST_DONE_XFER: begin
				// 16-bit word returned for the 8-bit address
				rdata_nxt = wr_r ? rdata_r : shreg_r[15:0];
				done_nxt  = 1'b1;
				auto_nxt  = 1'b0;
				state_nxt = ST_IDLE;
				if (auto_r && addr_r != secl_pkg::SIG_ADDR) begin
					// write fetched word to its register
					cfg_nxt.we   = 1'b1;
					cfg_nxt.addr = addr_r;
					cfg_nxt.data = shreg_r[15:0];
					// PM words at byte offsets 50h..5Ah
					pm_nxt = (addr_r >= secl_pkg::PM_WORD_BASE) &&
						(addr_r < secl_pkg::PM_WORD_BASE + 8'h6);
					// TC/VC map words at byte offsets 60h..6Ah
					tcvc_nxt = (addr_r >= secl_pkg::TCVC_WORD_BASE) &&
						(addr_r < secl_pkg::TCVC_WORD_BASE + 8'h6);
				end
				if (auto_r && addr_r != secl_pkg::LOAD_LAST &&
					(addr_r != secl_pkg::SIG_ADDR ||
					shreg_r[15:0] == secl_pkg::SIG_VALUE)) begin
					// step to the next consecutive word
					addr_nxt  = (addr_r == secl_pkg::SIG_ADDR) ?
						secl_pkg::LOAD_FIRST : addr_r + 8'h1;
					shreg_nxt = {secl_pkg::OP_READ, addr_nxt, 16'h0000};
					bits_nxt  = secl_pkg::BITS_RD;
					cs_nxt    = 1'b0;
					mosi_nxt  = secl_pkg::OP_READ[7];
					auto_nxt  = 1'b1;
					done_nxt  = 1'b0;
					state_nxt = ST_XFER;
				end
			end
			// requests honoured only while idle and done
			ST_IDLE: begin
				if (req_i.start) begin
					done_nxt = 1'b0;
					wr_nxt   = req_i.write;
					addr_nxt = req_i.addr;
					div_nxt  = 3'h0;
					cs_nxt   = 1'b0;
					if (req_i.write) begin
						rdata_nxt = req_i.wdata;
						shreg_nxt = {secl_pkg::OP_WREN, 24'h000000};
						mosi_nxt  = secl_pkg::OP_WREN[7];
						bits_nxt  = secl_pkg::BITS_WREN;
						state_nxt = ST_WREN;
					end else begin
						shreg_nxt = {secl_pkg::OP_READ, req_i.addr, 16'h0000};
						mosi_nxt  = secl_pkg::OP_READ[7];
						bits_nxt  = secl_pkg::BITS_RD;
						state_nxt = ST_XFER;
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			state_r <= ST_RESET;
			auto_r  <= 1'b0;
			wr_r    <= 1'b0;
			addr_r  <= 8'h00;
			shreg_r <= 32'h0;
			bits_r  <= 6'h0;
			div_r   <= 3'h0;
			sck_r   <= 1'b0;
			cs_r    <= 1'b1;
			mosi_r  <= 1'b0;
			done_r  <= 1'b0;
			rdata_r <= secl_pkg::WORD_RST;
			cfg_r   <= '0;
			pm_r    <= 1'b0;
			tcvc_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			auto_r  <= auto_nxt;
			wr_r    <= wr_nxt;
			addr_r  <= addr_nxt;
			shreg_r <= shreg_nxt;
			bits_r  <= bits_nxt;
			div_r   <= div_nxt;
			sck_r   <= sck_nxt;
			cs_r    <= cs_nxt;
			mosi_r  <= mosi_nxt;
			done_r  <= done_nxt;
			rdata_r <= rdata_nxt;
			cfg_r   <= cfg_nxt;
			pm_r    <= pm_nxt;
			tcvc_r  <= tcvc_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign cfgmem_serial_clock_o = sck_r;
	assign cfgmem_chip_select_o  = cs_r;
	assign cfgmem_data_in_o      = mosi_r;
	assign cfg_wr_o              = cfg_r;
	assign rdata_o               = rdata_r;
	assign pm_wr_o               = pm_r;
	assign tcvc_wr_o             = tcvc_r;
	assign status_o = 16'(done_r) << secl_pkg::STAT_DONE_BIT;

	// ==========================================================
	// Assertions
	sck_idle_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		cs_r |-> !sck_r) else $error("serial clock moves while deselected");
	cs_frame_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		$fell(cs_r) |-> cs_r == 1'b0 [*8]) else $error("select frame too short");
	hold_reset_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(state_r == ST_RESET && !perst_sync_r[1]) |=> cs_r)
		else $error("access before reset release");
	done_stat_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		status_o[4] |-> state_r == ST_IDLE) else $error("done while busy");
	sig_skip_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(state_r == ST_DONE_XFER && auto_r && addr_r == 8'h00 &&
		shreg_r[15:0] != secl_pkg::SIG_VALUE) |=> done_r && !cfg_r.we)
		else $error("load ran without signature");
	seq_step_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		cfg_r.we && cfg_r.addr != 8'h7f |-> addr_r == cfg_r.addr + 8'h1)
		else $error("autoload address not consecutive");
	pm_range_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		pm_r |-> cfg_r.addr >= 8'h28 && cfg_r.addr <= 8'h2d)
		else $error("pm strobe out of range");
	tcvc_range_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		tcvc_r |-> cfg_r.addr >= 8'h30 && cfg_r.addr <= 8'h35)
		else $error("tcvc strobe out of range");

endmodule

`default_nettype wire

// >>> secl_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Serial configuration memory, clock mode 0.
// ==========
module secl_mem_model (
	input  wire logic sck_i,
	input  wire logic cs_n_i,
	input  wire logic mosi_i,
	output logic      miso_o
);
	logic [15:0] mem [256];
	logic [31:0] sh;
	logic [7:0]  op;
	logic [7:0]  adr;
	int          cnt;
	logic        wel;
	initial begin
		miso_o = 1'b0;
		wel = 1'b0;
		cnt = 0;
	end
	always @(negedge cs_n_i) begin
		cnt = 0;
	end
	// A released data line shows no stale value.
	always @(posedge cs_n_i) begin
		miso_o = ~miso_o;
	end
	always @(posedge sck_i) begin
		if (!cs_n_i) begin
			sh = {sh[30:0], mosi_i};
			cnt = cnt + 1;
			if (cnt == 8 && sh[7:0] == secl_pkg::OP_WREN)
				wel = 1'b1;
			if (cnt == 16) begin
				op = sh[15:8];
				adr = sh[7:0];
			end
			if (cnt == 32 && op == secl_pkg::OP_WRITE && wel) begin
				mem[adr] = sh[15:0];
				wel = 1'b0;
			end
		end
	end
	always @(negedge sck_i) begin
		if (!cs_n_i && cnt >= 16 && cnt < 32 && op == secl_pkg::OP_READ)
			miso_o = mem[adr][31 - cnt];
		else
			miso_o = ~miso_o;
	end
endmodule
`default_nettype wire

// >>> secl_pkg.sv
package secl_pkg;

	// SPI serial memory opcodes (standard read, write and write enable).
	localparam logic [7:0] OP_READ  = 8'h03;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] OP_WREN  = 8'h06;

	// Memory layout in words and autoload span.
	localparam logic [7:0] SIG_ADDR      = 8'h00;
	localparam logic [7:0] LOAD_FIRST    = 8'h01;
	localparam logic [7:0] LOAD_LAST     = 8'h7f;
	localparam logic [7:0] PM_WORD_BASE  = 8'h28;
	localparam logic [7:0] TCVC_WORD_BASE = 8'h30;
	localparam logic [15:0] SIG_VALUE    = 16'h516e;

	// Serial clock half period in system clocks, word reset value and frame bit counts.
	localparam int          HALF_CYC     = 4;
	localparam logic [15:0] WORD_RST     = 16'h0000;
	localparam logic [5:0]  BITS_RD      = 6'd32;
	localparam logic [5:0]  BITS_WR      = 6'd32;
	localparam logic [5:0]  BITS_WREN    = 6'd8;

	// Status bit position in the load-status word.
	localparam int          STAT_DONE_BIT = 4;

	typedef struct packed {
		logic       start;
		logic       write;
		logic [7:0] addr;
		logic [15:0] wdata;
	} secl_req_t;

	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [15:0] data;
	} secl_cfg_wr_t;

endpackage

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
	logic                   mclk_i;
	logic                   rstn_i;
	logic                   fund_n;
	logic                   miso;
	logic                   sck;
	logic                   cs_n;
	logic                   mosi;
	logic                   pm_wr;
	logic                   tc_wr;
	logic                   loading;
	logic [7:0]             exp_a;
	logic [15:0]            status;
	logic [15:0]            rdata;
	secl_pkg::secl_req_t    req;
	secl_pkg::secl_cfg_wr_t cfg_wr;
	int                     n_mismatch;
	int                     samples_checked;
	int                     n_wr;
	int                     n_pm;
	int                     n_tc;
	secl_loader dut (
		.mclk_i               (mclk_i),
		.rstn_i               (rstn_i),
		.fundamental_reset_n_i(fund_n),
		.cfgmem_data_out_i    (miso),
		.req_i                (req),
		.cfgmem_serial_clock_o(sck),
		.cfgmem_chip_select_o (cs_n),
		.cfgmem_data_in_o     (mosi),
		.cfg_wr_o             (cfg_wr),
		.status_o             (status),
		.rdata_o              (rdata),
		.pm_wr_o              (pm_wr),
		.tcvc_wr_o            (tc_wr)
	);
	secl_mem_model mem_m (
		.sck_i (sck),
		.cs_n_i(cs_n),
		.mosi_i(mosi),
		.miso_o(miso)
	);
	initial mclk_i = 1'b0;
	always #2 mclk_i = ~mclk_i;
	// ==========
	// Loaded-word monitor.
	// ==========
	always @(posedge mclk_i) begin
		if (loading && cfg_wr.we === 1'b1) begin
			`CHK(cfg_wr.addr, exp_a)
			`CHK(cfg_wr.data, mem_m.mem[exp_a])
			`CHK(pm_wr, exp_a >= 8'h28 && exp_a <= 8'h2d)
			`CHK(tc_wr, exp_a >= 8'h30 && exp_a <= 8'h35)
			n_wr++;
			n_pm += int'(pm_wr);
			n_tc += int'(tc_wr);
			exp_a++;
		end
	end
	task automatic tick;
		@(posedge mclk_i);
		#1;
	endtask
	task automatic wait_done;
		for (int i = 0; i < 60000 && status !== 16'h0010; i++)
			tick();
		`CHK(status, 16'h0010)
	endtask
	task automatic do_reset(input logic [15:0] sig);
		mem_m.mem[0] = sig;
		rstn_i = 1'b0;
		fund_n = 1'b0;
		loading = 1'b1;
		exp_a = 8'h01;
		n_wr = 0;
		n_pm = 0;
		n_tc = 0;
		repeat (2) tick();
		rstn_i = 1'b1;
		for (int i = 0; i < 40; i++) begin
			tick();
			`CHK(cs_n, 1'b1)
		end
		fund_n = 1'b1;
	endtask
	task automatic access(input logic wr, input logic [7:0] a,
			input logic [15:0] d);
		req = '{1'b1, wr, a, d};
		tick();
		req = '{1'b0, 1'b0, ~a, ~d};
		tick();
		`CHK(status[4], 1'b0)
		// A start while busy must be ignored.
		req = '{1'b1, 1'b0, 8'h7f, 16'h0000};
		tick();
		req.start = 1'b0;
		// poll the done status before any further start.
		wait_done();
	endtask
	task automatic t_no_sig;
		do_reset(~secl_pkg::SIG_VALUE);
		wait_done();
		`CHK(n_wr, 0)
	endtask
	task automatic t_load;
		do_reset(secl_pkg::SIG_VALUE);
		tick();
		`CHK(status[4], 1'b0)
		wait_done();
		// The last word's strobe is sampled one edge after done rises.
		tick();
		loading = 1'b0;
		`CHK(n_wr, 127)
		`CHK(n_pm, 6)
		`CHK(n_tc, 6)
	endtask
	task automatic t_read;
		logic [7:0] al [3] = '{8'h00, 8'h2a, 8'hff};
		foreach (al[i]) begin
			access(1'b0, al[i], 16'h0000);
			`CHK(rdata, mem_m.mem[al[i]])
			`CHK(mem_m.op, secl_pkg::OP_READ)
			`CHK(mem_m.adr, al[i])
			`CHK(mem_m.cnt, 32)
		end
	endtask
	task automatic t_write;
		access(1'b1, 8'hc3, 16'ha55a);
		`CHK(mem_m.mem[8'hc3], 16'ha55a)
		access(1'b0, 8'hc3, 16'h0000);
		`CHK(rdata, 16'ha55a)
	endtask
	task automatic complete_run;
		$display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#250000;
		n_mismatch++;
		complete_run();
	end
	initial begin
		rstn_i = 1'b0;
		fund_n = 1'b0;
		loading = 1'b0;
		req = '0;
		n_mismatch = 0;
		samples_checked = 0;
		for (int i = 0; i < 256; i++)
			mem_m.mem[i] = {i[7:0] ^ 8'h5a, ~i[7:0]};
		t_no_sig();
		t_load();
		t_read();
		t_write();
		complete_run();
	end
endmodule
`default_nettype wire
